/* File: shared/fsei_pkg.sv */
// Package for the flash status and error interrupt block
package fsei_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 8;
   localparam logic [7:0]  OFF_CONFIG      = 8'h04;
   localparam logic [7:0]  OFF_ERR_EN      = 8'h05;
   localparam logic [7:0]  OFF_STATUS      = 8'h06;
   localparam logic [7:0]  OFF_ERR_STAT    = 8'h07;
   localparam logic [7:0]  OFF_IRQ_STAT    = 8'h08;
   localparam logic [7:0]  OFF_IRQ_MASK    = 8'h09;
   localparam int          BIT_CC          = 7;
   localparam int          BIT_ACCESS_ERROR_FLAG      = 5;
   localparam int          BIT_PVIOL       = 4;
   localparam int          BIT_BUSY        = 3;
   localparam int          BIT_DF          = 1;
   localparam int          BIT_SF          = 0;
   localparam int          BIT_CC_IE       = 7;
   localparam logic [7:0]  ERR_EN_MASK     = 8'h03;
   localparam logic [7:0]  CONFIG_MASK     = 8'h80;
   localparam logic [7:0]  IRQ_BITS_MASK   = 8'h0F;
   localparam logic [7:0]  RESET_ZERO      = 8'h00;
   // Event bits in the sticky status register
   localparam int          EV_DONE         = 0;
   localparam int          EV_ACCESS_ERROR_FLAG       = 1;
   localparam int          EV_PVIOL        = 2;
   localparam int          EV_FAULT        = 3;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } fsei_bus_req_t;

   typedef struct packed {
      logic seq_violation;
      logic illegal_cmd;
      logic prot_violation;
      logic cmd_done;
      logic single_fault;
      logic double_fault;
   } fsei_events_t;
endpackage : fsei_pkg

/* File: rtl/fsei_top.sv */
// Flash command status, error flags and interrupt requests
//
// Summary of operation
// R01: Reserved enable and status bits read zero
// R02: Double fault interrupt gated by its enable
// R03: Single fault interrupt gated by its enable
// R04: Enable gates request only, never the flag
// R05: Complete flag high when idle, low busy
// R06: Writing one to complete flag launches command
// R07: Access error set on sequence or illegal command
// R08: Access error blocks launch and flag clear
// R09: Access error cleared only by writing one
// R10: Protection flag set on protected program/erase
// R11: Protection flag cleared by writing one
// R12: Protection flag blocks launch and new sequence
// R13: Complete interrupt when enabled and flag set
// R14: Busy flag reads one while command runs
// R15: Double fault flag cleared by writing one
// R16: Fault requests are levels following flag and enable
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module fsei_top
   import fsei_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire fsei_bus_req_t       bus,
   output logic [DATA_W-1:0]        rdata,
   input  wire fsei_events_t        ev,
   output logic                     cmd_launch,
   output logic                     seq_allowed,
   output logic                     cc_irq,
   output logic                     sf_irq,
   output logic                     df_irq,
   output logic                     irq
);

   logic [7:0] cfg_reg;
   logic [7:0] err_en_reg;
   logic       cc_reg;
   logic       access_error_flag_reg;
   logic       pviol_reg;
   logic       sf_reg;
   logic       df_reg;
   logic [7:0] ist_reg;
   logic [7:0] imask_reg;
   logic       wr_status;
   logic       wr_err_stat;
   logic       launch_ok;
   logic       access_error_flag_set;
   logic [7:0] ev_vec;
   logic [7:0] rdata_next;

   function automatic logic wr_hit(input fsei_bus_req_t b, input logic [7:0] off);
      return b.wr && (b.addr == off);
   endfunction : wr_hit

   assign wr_status   = wr_hit(bus, OFF_STATUS);
   assign wr_err_stat = wr_hit(bus, OFF_ERR_STAT);
   // Launch needs idle controller and both error flags clear
   assign launch_ok   = wr_status && bus.wdata[BIT_CC] && cc_reg
                        && !access_error_flag_reg && !pviol_reg; // see R08 // see R12
   assign access_error_flag_set  = ev.seq_violation || ev.illegal_cmd;

   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_reg    <= RESET_ZERO;
         err_en_reg <= RESET_ZERO;
         imask_reg  <= RESET_ZERO;
      end else begin
         if (wr_hit(bus, OFF_CONFIG))
            cfg_reg <= bus.wdata & CONFIG_MASK;
         if (wr_hit(bus, OFF_ERR_EN))
            err_en_reg <= bus.wdata & ERR_EN_MASK; // see R01
         if (wr_hit(bus, OFF_IRQ_MASK))
            imask_reg <= bus.wdata & IRQ_BITS_MASK;
      end
   end

   // Unused enable bits are masked on write, so reads come back zero
   a_err_en_read: assert property (@(posedge clk) disable iff (rst) // see R01
      bus.rd && bus.addr == OFF_ERR_EN |=> rdata[7:2] == 6'h00)
      else $error("reserved enable bits read nonzero");

   // Command complete flag; completion or violation returns it high
   always_ff @(posedge clk) begin
      if (rst) begin
         cc_reg <= 1'b1;
      end else if (launch_ok) begin
         cc_reg <= 1'b0; // see R06
      end else if (!cc_reg && (ev.cmd_done || access_error_flag_set || ev.prot_violation)) begin
         cc_reg <= 1'b1; // see R05
      end
   end

   // Complete flag moves only on launch, completion or a violation
   a_cc_launch_low: assert property (@(posedge clk) disable iff (rst) // see R06
      launch_ok |=> !cc_reg && cmd_launch)
      else $error("launch did not clear complete flag");
   a_cc_low_hold: assert property (@(posedge clk) disable iff (rst) // see R06
      !cc_reg && !ev.cmd_done && !access_error_flag_set && !ev.prot_violation |=> !cc_reg)
      else $error("complete flag rose without an ending event");
   a_cc_done: assert property (@(posedge clk) disable iff (rst) // see R05
      !cc_reg && ev.cmd_done |=> cc_reg)
      else $error("complete flag not set on completion");
   a_cc_violation_end: assert property (@(posedge clk) disable iff (rst) // see R06
      !cc_reg && (access_error_flag_set || ev.prot_violation) |=> cc_reg)
      else $error("violation did not end the command");

   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_launch <= 1'b0;
      end else begin
         cmd_launch <= launch_ok; // see R06
      end
   end

   a_launch_pulse: assert property (@(posedge clk) disable iff (rst) // see R06
      cmd_launch |=> !cmd_launch)
      else $error("launch pulse longer than one cycle");
   a_access_error_flag_blocks: assert property (@(posedge clk) disable iff (rst) // see R08
      access_error_flag_reg |=> !cmd_launch)
      else $error("launch while access error set");

   // Set wins over a same-cycle write-one clear
   always_ff @(posedge clk) begin
      if (rst) begin
         access_error_flag_reg <= 1'b0;
      end else if (access_error_flag_set) begin
         access_error_flag_reg <= 1'b1; // see R07
      end else if (wr_status && bus.wdata[BIT_ACCESS_ERROR_FLAG]) begin
         access_error_flag_reg <= 1'b0; // see R09
      end
   end

   // A zero written to the bit must leave the flag alone
   a_access_error_flag_set: assert property (@(posedge clk) disable iff (rst) // see R07
      access_error_flag_set |=> access_error_flag_reg)
      else $error("access error not set");
   a_access_error_flag_hold: assert property (@(posedge clk) disable iff (rst) // see R09
      access_error_flag_reg && !(wr_status && bus.wdata[BIT_ACCESS_ERROR_FLAG]) |=> access_error_flag_reg)
      else $error("access error cleared without write one");
   a_access_error_flag_clear: assert property (@(posedge clk) disable iff (rst) // see R09
      access_error_flag_reg && wr_status && bus.wdata[BIT_ACCESS_ERROR_FLAG] && !access_error_flag_set |=> !access_error_flag_reg)
      else $error("access error not cleared by write one");
   a_access_error_flag_keeps_cc: assert property (@(posedge clk) disable iff (rst) // see R08
      access_error_flag_reg && cc_reg |=> cc_reg)
      else $error("complete flag cleared while access error set");

   always_ff @(posedge clk) begin
      if (rst) begin
         pviol_reg <= 1'b0;
      end else if (ev.prot_violation) begin
         pviol_reg <= 1'b1; // see R10
      end else if (wr_status && bus.wdata[BIT_PVIOL]) begin
         pviol_reg <= 1'b0; // see R11
      end
   end

   // Protection flag stays until software writes one to it
   a_pviol_flag: assert property (@(posedge clk) disable iff (rst) // see R10 R11
      ev.prot_violation ##1 !(wr_status && bus.wdata[BIT_PVIOL]) |=> pviol_reg)
      else $error("protection flag lost");
   a_pviol_hold: assert property (@(posedge clk) disable iff (rst) // see R11
      pviol_reg && !(wr_status && bus.wdata[BIT_PVIOL]) |=> pviol_reg)
      else $error("protection flag cleared without write one");
   a_pviol_clear: assert property (@(posedge clk) disable iff (rst) // see R11
      pviol_reg && wr_status && bus.wdata[BIT_PVIOL] && !ev.prot_violation |=> !pviol_reg)
      else $error("protection flag not cleared by write one");
   a_pviol_keeps_cc: assert property (@(posedge clk) disable iff (rst) // see R12
      pviol_reg && cc_reg |=> cc_reg)
      else $error("complete flag cleared while protection flag set");

   // Fault flags are never touched by the enables
   always_ff @(posedge clk) begin
      if (rst) begin
         sf_reg <= 1'b0;
         df_reg <= 1'b0;
      end else begin
         if (ev.single_fault)
            sf_reg <= 1'b1;
         else if (wr_err_stat && bus.wdata[BIT_SF])
            sf_reg <= 1'b0;
         if (ev.double_fault)
            df_reg <= 1'b1; // see R04
         else if (wr_err_stat && bus.wdata[BIT_DF])
            df_reg <= 1'b0; // see R15
      end
   end

   // Enables never reach the fault flags, only the requests
   a_df_clear: assert property (@(posedge clk) disable iff (rst) // see R15 R16
      wr_err_stat && bus.wdata[BIT_DF] && !ev.double_fault |=> !df_reg ##1 !df_irq)
      else $error("double fault clear failed");
   a_df_keep: assert property (@(posedge clk) disable iff (rst) // see R04
      df_reg && !(wr_err_stat && bus.wdata[BIT_DF]) |=> df_reg)
      else $error("double fault flag lost");
   a_sf_keep: assert property (@(posedge clk) disable iff (rst) // see R04
      sf_reg && !(wr_err_stat && bus.wdata[BIT_SF]) |=> sf_reg)
      else $error("single fault flag lost");

   always_ff @(posedge clk) begin
      if (rst) begin
         seq_allowed <= 1'b1;
      end else begin
         seq_allowed <= !pviol_reg; // see R12
      end
   end

   // Sequence permission follows the flag one cycle late
   a_pviol_blocks: assert property (@(posedge clk) disable iff (rst) // see R12
      pviol_reg |=> !cmd_launch && !seq_allowed)
      else $error("launch or sequence while protection flag set");
   a_seq_follow: assert property (@(posedge clk) disable iff (rst) // see R12
      !pviol_reg |=> seq_allowed)
      else $error("sequence refused without protection flag");

   // Level requests, one cycle behind the flag
   always_ff @(posedge clk) begin
      if (rst) begin
         cc_irq <= 1'b0;
         sf_irq <= 1'b0;
         df_irq <= 1'b0;
      end else begin
         cc_irq <= cfg_reg[BIT_CC_IE] && cc_reg; // see R13
         sf_irq <= err_en_reg[BIT_SF] && sf_reg; // see R03 // see R16
         df_irq <= err_en_reg[BIT_DF] && df_reg; // see R02 // see R16
      end
   end

   // Requests lag their flag by one cycle, so checks look one edge on
   a_df_irq: assert property (@(posedge clk) disable iff (rst) // see R02
      df_reg && err_en_reg[BIT_DF] ##1 df_reg |-> df_irq)
      else $error("double fault request missing");
   a_df_irq_off: assert property (@(posedge clk) disable iff (rst) // see R02
      !err_en_reg[BIT_DF] |=> !df_irq)
      else $error("double fault request while disabled");
   a_sf_irq: assert property (@(posedge clk) disable iff (rst) // see R03
      !err_en_reg[BIT_SF] |=> !sf_irq)
      else $error("single fault request while disabled");
   a_sf_irq_on: assert property (@(posedge clk) disable iff (rst) // see R03 R16
      sf_reg && err_en_reg[BIT_SF] |=> sf_irq)
      else $error("single fault request missing");
   a_cc_irq: assert property (@(posedge clk) disable iff (rst) // see R13
      cfg_reg[BIT_CC_IE] && cc_reg |=> cc_irq)
      else $error("complete request missing");
   a_cc_irq_off: assert property (@(posedge clk) disable iff (rst) // see R13
      !(cfg_reg[BIT_CC_IE] && cc_reg) |=> !cc_irq)
      else $error("complete request without flag and enable");

   always_comb begin
      ev_vec = 8'h00;
      ev_vec[EV_DONE]   = ev.cmd_done && !cc_reg;
      ev_vec[EV_ACCESS_ERROR_FLAG] = access_error_flag_set;
      ev_vec[EV_PVIOL]  = ev.prot_violation;
      ev_vec[EV_FAULT]  = ev.single_fault || ev.double_fault;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ist_reg <= RESET_ZERO;
      end else begin
         if (wr_hit(bus, OFF_IRQ_STAT))
            ist_reg <= ((ist_reg & ~bus.wdata) | ev_vec) & IRQ_BITS_MASK;
         else
            ist_reg <= (ist_reg | ev_vec) & IRQ_BITS_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ist_reg & imask_reg);
      end
   end

   always_comb begin
      rdata_next = 8'h00;
      unique case (bus.addr)
         OFF_CONFIG:   rdata_next = cfg_reg;
         OFF_ERR_EN:   rdata_next = err_en_reg; // see R01
         OFF_STATUS:   rdata_next = {cc_reg, 1'b0, access_error_flag_reg, pviol_reg,
                                     !cc_reg, 3'b000}; // see R01 // see R14
         OFF_ERR_STAT: rdata_next = {6'h00, df_reg, sf_reg};
         OFF_IRQ_STAT: rdata_next = ist_reg;
         OFF_IRQ_MASK: rdata_next = imask_reg;
         default:      rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= bus.rd ? rdata_next : 8'h00;
      end
   end

   // Busy is derived from the complete flag, so the two never disagree
   a_busy_read: assert property (@(posedge clk) disable iff (rst) // see R05 R14 R01
      bus.rd && bus.addr == OFF_STATUS |=> rdata[BIT_BUSY] == !rdata[BIT_CC]
      && rdata[6] == 1'b0)
      else $error("status read inconsistent");

endmodule : fsei_top
`default_nettype wire

/* File: verification/fsei_cpu_model.sv */
// CPU-side register bus master model for the flash status block
`timescale 1ns/1ps
`default_nettype none
module fsei_cpu_model
   import fsei_pkg::*;
(
   input  wire logic              clk,
   input  wire logic [DATA_W-1:0] rdata,
   output var fsei_bus_req_t      bus
);
   initial bus = '0;

   // Strobes go up and down on rising edges only, so the slave sees one-cycle pulses
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample just after that edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd
endmodule : fsei_cpu_model
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking testbench for the flash status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
   import fsei_pkg::*;
   logic              clk;
   logic              rst;
   fsei_bus_req_t     bus;
   fsei_events_t      ev;
   logic [DATA_W-1:0] rdata;
   logic              cmd_launch;
   logic              seq_allowed;
   logic              cc_irq;
   logic              sf_irq;
   logic              df_irq;
   logic              irq;
   int                bad_count;
   int                checked;

   fsei_top i_fsei_top (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .ev(ev),
      .cmd_launch(cmd_launch), .seq_allowed(seq_allowed), .cc_irq(cc_irq),
      .sf_irq(sf_irq), .df_irq(df_irq), .irq(irq));
   fsei_cpu_model i_fsei_cpu_model (.clk(clk), .rdata(rdata), .bus(bus));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_fsei_cpu_model.wr(a, d);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      i_fsei_cpu_model.rd(a, d);
      `CHK("rdata", e, d)
   endtask : rchk

   // Order of the event fields: seq, illegal, protect, done, single, double
   task automatic pulse(input logic [5:0] e);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= '0;
   endtask : pulse

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic t_reset;
      rchk(OFF_STATUS, 8'h80);
      rchk(OFF_ERR_EN, 8'h00);
      `CHK("seq_allowed", 1'b1, seq_allowed)
   endtask : t_reset

   task automatic t_reserved;
      wr(OFF_ERR_EN, 8'hFF);
      rchk(OFF_ERR_EN, 8'h03);
      wr(OFF_STATUS, 8'h40);
      rchk(OFF_STATUS, 8'h80);
      rchk(8'h20, 8'h00);
      wr(OFF_ERR_EN, 8'h00);
   endtask : t_reserved

   task automatic t_faults;
      pulse(6'h03);
      tick(3);
      `CHK("sf_irq", 1'b0, sf_irq)
      `CHK("df_irq", 1'b0, df_irq)
      rchk(OFF_ERR_STAT, 8'h03);
      wr(OFF_ERR_EN, 8'h03);
      tick(2);
      `CHK("sf_irq", 1'b1, sf_irq)
      `CHK("df_irq", 1'b1, df_irq)
      wr(OFF_ERR_STAT, 8'h02);
      tick(2);
      `CHK("df_irq", 1'b0, df_irq)
      `CHK("sf_irq", 1'b1, sf_irq)
      rchk(OFF_ERR_STAT, 8'h01);
      wr(OFF_ERR_STAT, 8'h01);
   endtask : t_faults

   task automatic t_launch;
      wr(OFF_CONFIG, 8'h80);
      wr(OFF_STATUS, 8'h80);
      #1;
      `CHK("cmd_launch", 1'b1, cmd_launch)
      rchk(OFF_STATUS, 8'h08);
      pulse(6'h04);
      tick(2);
      `CHK("cc_irq", 1'b1, cc_irq)
      rchk(OFF_IRQ_STAT, 8'h09);
      rchk(OFF_STATUS, 8'h80);
      `CHK("irq", 1'b0, irq)
      wr(OFF_IRQ_MASK, 8'h01);
      tick(2);
      `CHK("irq", 1'b1, irq)
      wr(OFF_IRQ_STAT, 8'h0F);
      tick(2);
      `CHK("irq", 1'b0, irq)
      rchk(OFF_IRQ_STAT, 8'h00);
   endtask : t_launch

   task automatic t_access_error_flag;
      for (int i = 0; i < 2; i++) begin
         // A running command is ended by the violation
         wr(OFF_STATUS, 8'h80);
         #1;
         `CHK("cmd_launch", 1'b1, cmd_launch)
         pulse(i ? 6'h10 : 6'h20);
         rchk(OFF_STATUS, 8'hA0);
         wr(OFF_STATUS, 8'h80);
         #1;
         `CHK("cmd_launch", 1'b0, cmd_launch)
         rchk(OFF_STATUS, 8'hA0);
         wr(OFF_STATUS, 8'h00);
         rchk(OFF_STATUS, 8'hA0);
         wr(OFF_STATUS, 8'h20);
         rchk(OFF_STATUS, 8'h80);
      end
   endtask : t_access_error_flag

   task automatic t_protect;
      pulse(6'h08);
      rchk(OFF_STATUS, 8'h90);
      `CHK("seq_allowed", 1'b0, seq_allowed)
      wr(OFF_STATUS, 8'h80);
      #1;
      `CHK("cmd_launch", 1'b0, cmd_launch)
      wr(OFF_STATUS, 8'h10);
      tick(2);
      `CHK("seq_allowed", 1'b1, seq_allowed)
      rchk(OFF_STATUS, 8'h80);
   endtask : t_protect

   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   initial begin
      rst = 1'b1;
      ev = '0;
      bad_count = 0;
      checked = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_reserved;
      t_faults;
      t_launch;
      t_access_error_flag;
      t_protect;
      stop_test;
   end

   // The whole sequence needs about 130 cycles; this leaves wide margin
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      stop_test;
   end
endmodule : tb
`default_nettype wire
